// *** rtl/aop_defs.svh ***
// Constants for the converter result output port.
`ifndef AOP_DEFS_SVH
`define AOP_DEFS_SVH
`define AOP_RES_W       18
`define AOP_MSB         17
`define AOP_CNT_W       16
`define AOP_BITS_W      5
`define AOP_MODE_PAR18  2'h0
`define AOP_MODE_WORD   2'h1
`define AOP_MODE_BYTE   2'h2
`define AOP_MODE_SER    2'h3
`define AOP_PIN_CODING  0
`define AOP_PIN_WORD    1
`define AOP_PIN_BYTE    2
`define AOP_PIN_SERIAL_RESULT_OUT   10
`define AOP_PIN_SCLK    11
`define AOP_PIN_SYNC    12
`define AOP_PIN_RDERR   13
`define AOP_BITS_FULL   5'h12
`define AOP_CONV_CYC    100
`define AOP_CAL_CYC     200
`define AOP_FIFO_DEPTH  4
`endif

// *** rtl/aop_pkg.sv ***
// Types shared by the converter result output port.
package aop_pkg;
    typedef enum logic [1:0] {AOP_IDLE, AOP_CAL, AOP_CONV, AOP_PUSH} aop_state_t;
    typedef struct packed {
        logic [17:0] out;
        logic [17:0] oe;
    } aop_bus_t;
endpackage

// *** rtl/aop_port.sv ***
// Result FIFO and the control and result output port of the converter.
`timescale 1ns/1ps
`default_nettype none
`include "aop_defs.svh"

// ----------------------------------------
// Result FIFO
// ----------------------------------------
module aop_fifo #(
    parameter int WIDTH = `AOP_RES_W,
    parameter int DEPTH = `AOP_FIFO_DEPTH
) (
    input  wire logic             clock_i,
    input  wire logic             resetn_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wp_ff, nxt_wp, rp_ff, nxt_rp;
    logic [AW:0]      cnt_ff, nxt_cnt;
    logic             wr, rd;

    always_comb begin
        in_ready_o  = (cnt_ff != (AW+1)'(DEPTH));
        out_valid_o = (cnt_ff != '0);
        out_data_o  = mem_ff[rp_ff];
        wr          = in_valid_i & in_ready_o;
        rd          = out_valid_o & out_ready_i;
        nxt_wp      = wr ? ((wp_ff == AW'(DEPTH-1)) ? '0 : wp_ff + 1'b1) : wp_ff;
        nxt_rp      = rd ? ((rp_ff == AW'(DEPTH-1)) ? '0 : rp_ff + 1'b1) : rp_ff;
        nxt_cnt     = cnt_ff + (AW+1)'(wr) - (AW+1)'(rd);
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            wp_ff  <= '0;
            rp_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            wp_ff  <= nxt_wp;
            rp_ff  <= nxt_rp;
            cnt_ff <= nxt_cnt;
        end
        if (wr) begin
            mem_ff[wp_ff] <= in_data_i;
        end
    end
endmodule

// ----------------------------------------
// Output port
// ----------------------------------------
// Operation
// - Data pins are driven only while chip select and read strobe are both low.
// - In slave serial mode, serial clock edges count only while chip select is low.
// - Reset input high holds the device idle and drops any running conversion.
// - Falling edge of reset starts calibration, shown by busy held high.
// - Power-down lets a running conversion finish, then blocks new starts.
// - Falling edge of convert start takes a sample and begins a conversion.
// - Mode pins choose 18-bit, 16-bit word, byte or serial read-out.
// - Byte mode puts the selected byte on the upper lanes, lower lanes released.
// - Outside 18-bit mode, pin D0 selects straight binary or twos complement.
// - Busy rises at conversion start and falls when the result is stored.
// - Unfinished slave serial read at new result loses data and pulses a flag.
module aop_port #(
    parameter int CONV_CYCLES = `AOP_CONV_CYC,
    parameter int CAL_CYCLES  = `AOP_CAL_CYC,
    parameter int FIFO_DEPTH  = `AOP_FIFO_DEPTH
) (
    input  wire logic                          clock_i,
    input  wire logic                          resetn_i,
    input  wire logic                          reset_i,
    input  wire logic                          power_down_in_i,
    input  wire logic                          convert_start_n_i,
    input  wire logic                          iface_mode_hi_i,
    input  wire logic                          iface_mode_lo_i,
    input  wire logic                          serial_clock_source_sel_i,
    input  wire logic                          cs_n_i,
    input  wire logic                          rd_n_i,
    input  wire logic [`AOP_MSB:0]             sample_i,
    input  wire logic [`AOP_MSB:0]             data_i,
    output var  aop_pkg::aop_bus_t             data_o,
    output logic                               busy_o
);
    import aop_pkg::*;

    aop_state_t             state_ff, nxt_state;
    logic [`AOP_CNT_W-1:0]  cnt_ff, nxt_cnt;
    logic [`AOP_MSB:0]      sample_ff, nxt_sample, out_ff, nxt_out, shift_ff, nxt_shift;
    logic [`AOP_MSB:0]      fifo_data, coded;
    logic [`AOP_BITS_W-1:0] bits_ff, nxt_bits;
    logic                   cnv_prev_ff, rst_prev_ff, sclk_prev_ff, mclk_ff, nxt_mclk;
    logic                   flag_ff, nxt_flag, nxt_busy;
    logic                   push, in_ready, fifo_valid, pop;
    logic                   start_fall, rst_fall, read_act, straight, slave_edge, master_shift;
    logic                   ser_mode, slave;
    logic [1:0]             mode;
    aop_bus_t               nxt_bus;

    assign mode       = {iface_mode_hi_i, iface_mode_lo_i};
    assign ser_mode   = (mode == `AOP_MODE_SER);
    assign slave      = ser_mode & serial_clock_source_sel_i;
    assign read_act   = ~cs_n_i & ~rd_n_i;
    assign start_fall = cnv_prev_ff & ~convert_start_n_i;
    assign rst_fall   = rst_prev_ff & ~reset_i;
    // In 18-bit mode D0 is a data output, so coding is fixed to straight binary.
    assign straight   = (mode == `AOP_MODE_PAR18) | data_i[`AOP_PIN_CODING];
    assign coded      = {out_ff[`AOP_MSB] ^ ~straight, out_ff[`AOP_MSB-1:0]};

    // ----------------------------------------
    // Conversion sequencer
    // ----------------------------------------
    always_comb begin
        nxt_state  = state_ff;
        nxt_cnt    = cnt_ff;
        nxt_sample = sample_ff;
        push       = 1'b0;
        if (reset_i) begin
            nxt_state = AOP_IDLE;
            nxt_cnt   = '0;
        end else begin
            unique case (state_ff)
                AOP_IDLE: begin
                    if (rst_fall) begin
                        nxt_state = AOP_CAL;
                        nxt_cnt   = `AOP_CNT_W'(CAL_CYCLES - 1);
                    end else if (start_fall && !power_down_in_i) begin
                        nxt_state  = AOP_CONV;
                        nxt_cnt    = `AOP_CNT_W'(CONV_CYCLES - 1);
                        nxt_sample = sample_i;
                    end
                end
                AOP_CAL, AOP_CONV: begin
                    if (cnt_ff == '0) begin
                        nxt_state = (state_ff == AOP_CAL) ? AOP_IDLE : AOP_PUSH;
                    end else begin
                        nxt_cnt = cnt_ff - 1'b1;
                    end
                end
                AOP_PUSH: begin
                    // A full FIFO holds the conversion here, keeping busy high.
                    push = 1'b1;
                    if (in_ready) begin
                        nxt_state = AOP_IDLE;
                    end
                end
            endcase
        end
        nxt_busy = (nxt_state != AOP_IDLE);
    end

    aop_fifo #(.WIDTH(`AOP_RES_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clock_i     (clock_i),
        .resetn_i    (resetn_i),
        .in_valid_i  (push),
        .in_ready_o  (in_ready),
        .in_data_i   (sample_ff),
        .out_valid_o (fifo_valid),
        .out_ready_i (pop),
        .out_data_o  (fifo_data)
    );

    // ----------------------------------------
    // Result latch and serial shifter
    // ----------------------------------------
    always_comb begin
        // A parallel read in progress holds the latch so the word stays coherent.
        pop          = fifo_valid & ~(read_act & ~ser_mode);
        slave_edge   = slave & ~cs_n_i & data_i[`AOP_PIN_SCLK] & ~sclk_prev_ff;
        nxt_mclk     = 1'b0;
        master_shift = 1'b0;
        if (ser_mode && !serial_clock_source_sel_i && read_act && bits_ff != `AOP_BITS_FULL) begin
            nxt_mclk     = ~mclk_ff;
            master_shift = mclk_ff;
        end
        nxt_out   = out_ff;
        nxt_shift = shift_ff;
        nxt_bits  = bits_ff;
        nxt_flag  = 1'b0;
        if (pop) begin
            nxt_out   = fifo_data;
            nxt_shift = {fifo_data[`AOP_MSB] ^ ~straight, fifo_data[`AOP_MSB-1:0]};
            nxt_bits  = '0;
            nxt_flag  = slave && bits_ff != '0 && bits_ff != `AOP_BITS_FULL;
        end else if ((slave_edge || master_shift) && bits_ff != `AOP_BITS_FULL) begin
            nxt_shift = {shift_ff[`AOP_MSB-1:0], 1'b0};
            nxt_bits  = bits_ff + 1'b1;
        end
    end

    // ----------------------------------------
    // Pin formatting
    // ----------------------------------------
    always_comb begin
        nxt_bus = '0;
        if (read_act) begin
            unique case (mode)
                `AOP_MODE_PAR18: begin
                    nxt_bus.out = out_ff;
                    nxt_bus.oe  = '1;
                end
                `AOP_MODE_WORD: begin
                    nxt_bus.out[`AOP_MSB:2] = data_i[`AOP_PIN_WORD] ? coded[15:0] : coded[`AOP_MSB:2];
                    nxt_bus.oe[`AOP_MSB:2]  = '1;
                end
                `AOP_MODE_BYTE: begin
                    unique case ({data_i[`AOP_PIN_WORD], data_i[`AOP_PIN_BYTE]})
                        2'h0:    nxt_bus.out[`AOP_MSB:10] = coded[`AOP_MSB:10];
                        2'h1:    nxt_bus.out[`AOP_MSB:10] = coded[9:2];
                        2'h2:    nxt_bus.out[11:10] = coded[1:0];
                        default: nxt_bus.out[`AOP_MSB:16] = coded[1:0];
                    endcase
                    nxt_bus.oe[`AOP_MSB:10] = '1;
                end
                `AOP_MODE_SER: begin
                    nxt_bus.out[`AOP_PIN_SERIAL_RESULT_OUT] = shift_ff[`AOP_MSB];
                    nxt_bus.out[`AOP_PIN_SCLK]  = mclk_ff;
                    nxt_bus.out[`AOP_PIN_SYNC]  = ~serial_clock_source_sel_i & (bits_ff != `AOP_BITS_FULL);
                    nxt_bus.out[`AOP_PIN_RDERR] = flag_ff;
                    nxt_bus.oe[`AOP_PIN_SERIAL_RESULT_OUT]  = 1'b1;
                    nxt_bus.oe[`AOP_PIN_SCLK]   = ~serial_clock_source_sel_i;
                    nxt_bus.oe[`AOP_PIN_SYNC]   = ~serial_clock_source_sel_i;
                    nxt_bus.oe[`AOP_PIN_RDERR]  = serial_clock_source_sel_i;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            state_ff     <= AOP_IDLE;
            cnt_ff       <= '0;
            sample_ff    <= '0;
            out_ff       <= '0;
            shift_ff     <= '0;
            bits_ff      <= `AOP_BITS_FULL;
            cnv_prev_ff  <= 1'b1;
            rst_prev_ff  <= 1'b0;
            sclk_prev_ff <= 1'b0;
            mclk_ff      <= 1'b0;
            flag_ff      <= 1'b0;
            busy_o       <= 1'b0;
            data_o       <= '0;
        end else begin
            state_ff     <= nxt_state;
            cnt_ff       <= nxt_cnt;
            sample_ff    <= nxt_sample;
            out_ff       <= nxt_out;
            shift_ff     <= nxt_shift;
            bits_ff      <= nxt_bits;
            cnv_prev_ff  <= convert_start_n_i;
            rst_prev_ff  <= reset_i;
            sclk_prev_ff <= data_i[`AOP_PIN_SCLK];
            mclk_ff      <= nxt_mclk;
            flag_ff      <= nxt_flag;
            busy_o       <= nxt_busy;
            data_o       <= nxt_bus;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    oe_gate_a: assert property ((data_o.oe != '0) |-> $past(read_act))
        else $error("Data pins driven without chip select and read.");
    sclk_gate_a: assert property (slave && cs_n_i && !pop |=> $stable(bits_ff))
        else $error("Serial clock counted with chip select high.");
    reset_abort_a: assert property (reset_i |=> state_ff == AOP_IDLE && !push)
        else $error("Conversion kept running during reset.");
    cal_busy_a: assert property ($fell(reset_i) && state_ff == AOP_IDLE |-> ##1 busy_o [*8])
        else $error("Calibration did not hold busy high.");
    pd_block_a: assert property (state_ff == AOP_IDLE && power_down_in_i |=> state_ff != AOP_CONV)
        else $error("Conversion started during power-down.");
    start_conv_a: assert property (state_ff == AOP_IDLE && start_fall && !reset_i && !rst_fall
                                   && !power_down_in_i |=> state_ff == AOP_CONV ##1 busy_o)
        else $error("Start edge did not begin a conversion.");
    par_map_a: assert property (read_act && mode == `AOP_MODE_PAR18 |=> data_o.out == $past(out_ff))
        else $error("18-bit read shows the wrong word.");
    byte_lanes_a: assert property (read_act && mode == `AOP_MODE_BYTE |=> data_o.oe[9:0] == '0)
        else $error("Byte mode drove a lower lane.");
    coding_a: assert property (read_act && mode == `AOP_MODE_WORD && !data_i[`AOP_PIN_WORD]
                               && !data_i[`AOP_PIN_CODING]
                               |=> data_o.out[`AOP_MSB] != $past(out_ff[`AOP_MSB]))
        else $error("Twos complement coding not applied.");
    busy_end_a: assert property ($fell(busy_o) && !$past(reset_i) && $past(state_ff) != AOP_CAL
                                 |-> $past(push && in_ready))
        else $error("Busy fell before the result was stored.");
    flag_pulse_a: assert property (flag_ff |=> !flag_ff)
        else $error("Incomplete read flag longer than one cycle.");
    stable_out_a: assert property (!pop |=> $stable(out_ff))
        else $error("Result changed without a new conversion.");
endmodule
`default_nettype wire

// *** test/aop_host.sv ***
// Host controller model that reads results from the converter port.
`timescale 1ns/1ps
`default_nettype none
module aop_host (
    input  wire logic              clock_i,
    input  wire logic              read_i,
    input  wire logic [2:0]        sel_i,
    input  wire logic [4:0]        nclk_i,
    input  wire logic              go_i,
    input  wire aop_pkg::aop_bus_t pins_i,
    output logic                   cs_n_o,
    output logic                   rd_n_o,
    output logic [17:0]            drive_o
);
    import aop_pkg::*;
    logic [4:0] left_ff  = 5'h0;
    logic [2:0] ph_ff    = 3'h0;
    logic       churn_ff = 1'b0;
    logic       sclk;
    // The serial clock stands still low outside a frame of pulses.
    always_ff @(posedge clock_i) begin
        churn_ff <= ~churn_ff;
        if (go_i) begin
            left_ff <= nclk_i;
            ph_ff   <= 3'h0;
        end else if (left_ff != 5'h0) begin
            ph_ff <= ph_ff + 3'h1;
            if (ph_ff == 3'h7) begin
                left_ff <= left_ff - 5'h1;
            end
        end
    end
    assign sclk   = (left_ff != 5'h0) && ph_ff[2];
    assign cs_n_o = ~read_i;
    assign rd_n_o = ~read_i;
    // Released lanes other than D0-D2 and the serial clock lane churn every cycle, so a stale value never reads as good.
    always_comb begin
        for (int k = 0; k < 18; k++) begin
            drive_o[k] = churn_ff ^ k[0];
        end
        drive_o[2:0] = sel_i;
        drive_o[11]  = sclk;
        for (int k = 0; k < 18; k++) begin
            if (pins_i.oe[k]) begin
                drive_o[k] = pins_i.out[k];
            end
        end
    end
endmodule
`default_nettype wire

// *** test/aop_port_tb.sv ***
// Self-checking bench for the converter result output port.
`timescale 1ns/1ps
`default_nettype none
module aop_port_tb;
    import aop_pkg::*;
    logic        clock_i;
    logic        resetn_i = 1'b0;
    logic        reset_i  = 1'b0;
    logic        pd       = 1'b0;
    logic        cnv_n    = 1'b1;
    logic        sser     = 1'b0;
    logic        rd       = 1'b0;
    logic        go       = 1'b0;
    logic        seen13   = 1'b0;
    logic [1:0]  mode     = 2'h0;
    logic [2:0]  sel      = 3'h0;
    logic [4:0]  nclk     = 5'h0;
    logic [17:0] smp      = 18'h0;
    logic [17:0] r;
    logic [17:0] pins;
    logic        cs_n;
    logic        rd_n;
    logic        busy_o;
    aop_bus_t    data_o;
    int          mismatches = 0;
    int          n_tests    = 0;
    aop_host u_aop_host (.clock_i(clock_i), .read_i(rd), .sel_i(sel), .nclk_i(nclk), .go_i(go),
        .pins_i(data_o), .cs_n_o(cs_n), .rd_n_o(rd_n), .drive_o(pins));
    aop_port #(.CONV_CYCLES(4), .CAL_CYCLES(8)) u_aop_port (.clock_i(clock_i),
        .resetn_i(resetn_i), .reset_i(reset_i), .power_down_in_i(pd), .convert_start_n_i(cnv_n),
        .iface_mode_hi_i(mode[1]), .iface_mode_lo_i(mode[0]), .serial_clock_source_sel_i(sser),
        .cs_n_i(cs_n), .rd_n_i(rd_n), .sample_i(smp), .data_i(pins), .data_o(data_o),
        .busy_o(busy_o));
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    // The flag is a one-cycle pulse, so it is caught by a monitor rather than polled.
    always @(posedge clock_i) if (mode == 2'h3 && data_o.out[13] === 1'b1) seen13 <= 1'b1;
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input string nm, input logic [17:0] seen, input logic [17:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    task automatic wait_busy(input logic lv);
        int k;
        k = 0;
        while (busy_o !== lv && k < 300) begin
            step(1);
            k++;
        end
        check("busy", busy_o, lv);
    endtask
    task automatic start();
        cnv_n = 1'b0;
        step(1);
        cnv_n = 1'b1;
    endtask
    task automatic convert(input logic [17:0] v);
        smp = v;
        start();
        wait_busy(1'b1);
        wait_busy(1'b0);
        step(4);
    endtask
    task automatic rd_on(input logic [1:0] m, input logic [2:0] s);
        mode = m;
        sel = s;
        rd = 1'b1;
        step(3);
    endtask
    task automatic rd_off();
        rd = 1'b0;
        step(2);
    endtask
    task automatic pulse(input logic [4:0] n);
        nclk = n;
        go = 1'b1;
        step(1);
        go = 1'b0;
        step(8 * int'(n) + 2);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_cal();
        reset_i = 1'b1;
        step(2);
        reset_i = 1'b0;
        step(3);
        check("cal_busy", busy_o, 1'b1);
        wait_busy(1'b0);
        $display("test cal done");
    endtask
    task automatic t_read();
        logic [7:0] e;
        r = 18'h2d5a3;
        convert(r);
        check("idle_oe", data_o.oe, 18'h0);
        rd_on(2'h0, 3'h0);
        check("par_out", data_o.out, r);
        check("par_oe", data_o.oe, 18'h3ffff);
        rd_off();
        rd_on(2'h1, 3'h1);
        check("word_hi", data_o.out[17:2], r[17:2]);
        rd_on(2'h1, 3'h3);
        check("word_lo", data_o.out[17:2], r[15:0]);
        rd_on(2'h1, 3'h0);
        check("twos", data_o.out[17:2], {~r[17], r[16:2]});
        for (int i = 0; i < 4; i++) begin
            rd_on(2'h2, {i[0], i[1], 1'b1});
            case (i)
                0: e = r[17:10];
                1: e = r[9:2];
                2: e = {6'h0, r[1:0]};
                default: e = {r[1:0], 6'h0};
            endcase
            check("byte", data_o.out[17:10], e);
            check("byte_oe", data_o.oe, 18'h3fc00);
        end
        rd_off();
        $display("test read done");
    endtask
    task automatic t_hold();
        rd_on(2'h0, 3'h0);
        convert(18'h1b2c4);
        check("held", data_o.out, r);
        rd_off();
        rd_on(2'h0, 3'h0);
        check("fresh", data_o.out, 18'h1b2c4);
        rd_off();
        $display("test hold done");
    endtask
    task automatic t_pd_abort();
        smp = 18'h0f0f0;
        start();
        step(3);
        pd = 1'b1;
        wait_busy(1'b0);
        step(4);
        rd_on(2'h0, 3'h0);
        check("pd_finish", data_o.out, 18'h0f0f0);
        rd_off();
        start();
        step(4);
        check("pd_block", busy_o, 1'b0);
        pd = 1'b0;
        smp = 18'h3ffff;
        start();
        step(3);
        reset_i = 1'b1;
        step(3);
        check("abort_busy", busy_o, 1'b0);
        reset_i = 1'b0;
        step(3);
        wait_busy(1'b0);
        step(4);
        rd_on(2'h0, 3'h0);
        check("abort_keep", data_o.out, 18'h0f0f0);
        rd_off();
        $display("test pd_abort done");
    endtask
    task automatic t_serial();
        logic [17:0] bits;
        mode = 2'h3;
        sser = 1'b1;
        sel = 3'h1;
        r = 18'h2a5c3;
        convert(r);
        pulse(5'h2);
        rd = 1'b1;
        step(2);
        for (int i = 17; i >= 0; i--) begin
            bits[i] = data_o.out[10];
            pulse(5'h1);
        end
        check("serial", bits, r);
        seen13 = 1'b0;
        convert(18'h15555);
        check("rd_noflag", seen13, 1'b0);
        pulse(5'h5);
        convert(18'h0a0a0);
        check("rd_flag", seen13, 1'b1);
        check("ser_new", data_o.out[10], 1'b0);
        rd_off();
        $display("test serial done");
    endtask
    task automatic t_master();
        logic [17:0] bits;
        int          n;
        bits = 18'h0;
        n = 0;
        mode = 2'h3;
        sser = 1'b0;
        sel = 3'h0;
        convert(18'h0c35a);
        rd = 1'b1;
        for (int k = 0; k < 44; k++) begin
            step(1);
            if (k == 4) begin
                check("m_sync_on", data_o.out[12], 1'b1);
            end
            if (data_o.out[11] === 1'b1) begin
                if (n < 18) begin
                    bits[17 - n] = data_o.out[10];
                end
                n++;
            end
        end
        check("m_clocks", 18'(n), 18'h12);
        check("m_data", bits, 18'h2c35a);
        check("m_sync_off", data_o.out[12], 1'b0);
        rd_off();
        $display("test master done");
    endtask
    initial begin
        step(4);
        resetn_i = 1'b1;
        step(1);
        check("rst_oe", data_o.oe, 18'h0);
        check("rst_busy", busy_o, 1'b0);
        t_cal();
        t_read();
        t_hold();
        t_pd_abort();
        t_serial();
        t_master();
        print_verdict();
    end
    initial begin
        #(40000 * 5);
        mismatches++;
        print_verdict();
    end
endmodule
`default_nettype wire
